// >>> src/dpw_regs.vh
`ifndef DPW_REGS_VH
`define DPW_REGS_VH
// Counter width and tap range
`define DPW_CNT_W 7
`define DPW_TAP_NUM 100
`define DPW_TAP_MAX 7'h63
`define DPW_TAP_MIN 7'h00
// Reset value of the position counter before the stored value is loaded
`define DPW_POS_RST 7'h00
// One step moves the counter by this much
`define DPW_POS_STEP 7'h01
// Controller states
`define DPW_ST_LOAD 1'b0
`define DPW_ST_RUN 1'b1
`endif

// >>> src/dpw_top.v
`timescale 1ns/100ps
`include "dpw_regs.vh"

module dpw_top #(
  parameter CNT_W = `DPW_CNT_W,
  parameter TAP_NUM = `DPW_TAP_NUM
) (
  input wire CORE_CLK_IN,
  input wire RST_IN,
  input wire SEL_N_IN,
  input wire DIR_IN,
  input wire STEP_IN,
  input wire [CNT_W-1:0] NV_RDATA_IN,
  output reg [CNT_W-1:0] POS_OUT,
  output wire [TAP_NUM-1:0] TAP_SEL_OUT,
  output reg NV_WR_OUT,
  output reg [CNT_W-1:0] NV_WDATA_OUT,
  output reg READY_OUT
);

  // ****************************************
  // Local constants
  // ****************************************
  // Controller states: the part either waits for the stored word or follows the host
  localparam [0:0] ST_LOAD = `DPW_ST_LOAD;
  localparam [0:0] ST_RUN = `DPW_ST_RUN;
  // Tap limits, reset value and step size at the counter width
  localparam [CNT_W-1:0] POS_MAX = `DPW_TAP_MAX;
  localparam [CNT_W-1:0] POS_MIN = `DPW_TAP_MIN;
  localparam [CNT_W-1:0] POS_RST = `DPW_POS_RST;
  localparam [CNT_W-1:0] POS_ONE = `DPW_POS_STEP;

  // ****************************************
  // Internal signals
  // ****************************************
  reg state;
  reg next_state;
  reg step_prev;
  reg sel_n_prev;
  reg moved;
  reg next_moved;
  reg [CNT_W-1:0] next_pos;
  reg [CNT_W-1:0] load_pos;
  wire step_rise;
  wire deselect;
  wire running;
  wire step_ok;
  wire at_top;
  wire at_bottom;
  wire pos_change;
  wire save_req;

  // ****************************************
  // Edge detection of the control lines
  // ****************************************
  // Last step level; reset high so a line already high at power-up is not taken as a step
  always @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      step_prev <= 1'b1;
    end else begin
      step_prev <= STEP_IN;
    end
  end

  // Last select level; reset to deselected so power-up never looks like a deselect
  always @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      sel_n_prev <= 1'b1;
    end else begin
      sel_n_prev <= SEL_N_IN;
    end
  end

  // Steps are taken on the rising edge of the step line, so a long pulse counts once
  assign step_rise = STEP_IN & ~step_prev;
  // A rising select line ends an access and may start a save
  assign deselect = SEL_N_IN & ~sel_n_prev;
  // Only a loaded counter follows the host
  assign running = (state == ST_RUN);
  // A step counts only while selected and after the stored word is in
  assign step_ok = step_rise & ~SEL_N_IN & running;

  // ****************************************
  // Load controller
  // ****************************************
  // The stored word is taken once, in the first cycle after reset, then the host is followed
  always @* begin
    next_state = state;
    case (state)
      ST_LOAD: begin
        next_state = ST_RUN;
      end
      ST_RUN: begin
        next_state = ST_RUN;
      end
      default: begin
        next_state = ST_LOAD;
      end
    endcase
  end

  // State register; reset models power coming back
  always @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      state <= ST_LOAD;
    end else begin
      state <= next_state;
    end
  end

  // Ready tells the host that steps are honoured from now on
  always @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      READY_OUT <= 1'b0;
    end else begin
      READY_OUT <= (next_state == ST_RUN);
    end
  end

  // ****************************************
  // Position counter
  // ****************************************
  // A corrupt stored value beyond the top tap is clamped rather than decoded to no tap at all
  always @* begin
    load_pos = NV_RDATA_IN;
    if (NV_RDATA_IN > POS_MAX) begin
      load_pos = POS_MAX;
    end
  end

  // Ends of the array, where a step in that direction is dropped
  assign at_top = (POS_OUT == POS_MAX);
  assign at_bottom = (POS_OUT == POS_MIN);

  // Next position: load once, then up or down by one, held at either end of the array
  always @* begin
    next_pos = POS_OUT;
    if (!running) begin
      next_pos = load_pos;
    end else if (step_ok) begin
      if (DIR_IN) begin
        if (!at_top) begin
          next_pos = POS_OUT + POS_ONE;
        end
      end else begin
        if (!at_bottom) begin
          next_pos = POS_OUT - POS_ONE;
        end
      end
    end
  end

  // Seven-bit up/down counter; after the load it holds whenever no step is taken
  always @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      POS_OUT <= POS_RST;
    end else begin
      POS_OUT <= next_pos;
    end
  end

  // ****************************************
  // Nonvolatile save on deselect
  // ****************************************
  // Only a real change marks a move; a step held at an end needs no wearing write
  assign pos_change = running & (next_pos != POS_OUT);
  // Select high and a counted step exclude each other, so the saved word is settled
  assign save_req = deselect & moved & running;

  // Move flag: cleared by a save, set by a change; the set wins if both fall in one cycle
  always @* begin
    next_moved = moved;
    if (save_req) begin
      next_moved = 1'b0;
    end
    if (pos_change) begin
      next_moved = 1'b1;
    end
  end

  // Move flag register; a reset forgets moves that were never saved, as power loss does
  always @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      moved <= 1'b0;
    end else begin
      moved <= next_moved;
    end
  end

  // Write strobe to the store, one cycle per save
  always @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      NV_WR_OUT <= 1'b0;
    end else begin
      NV_WR_OUT <= save_req;
    end
  end

  // Saved word; it holds until the next save so the store may take it late
  always @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      NV_WDATA_OUT <= POS_RST;
    end else begin
      if (save_req) begin
        NV_WDATA_OUT <= POS_OUT;
      end
    end
  end

  // ****************************************
  // One-hot tap decoder
  // ****************************************
  // Codes above the top tap cannot occur: loads are clamped and steps saturate
  genvar i;
  generate
    for (i = 0; i < TAP_NUM; i = i + 1) begin : g_tap
      // Tap index as a sized constant, so the compare is at the counter width
      localparam [31:0] TAP_IDX = i;
      assign TAP_SEL_OUT[i] = (POS_OUT == TAP_IDX[CNT_W-1:0]);
    end
  endgenerate

endmodule // dpw_top

// >>> bench/dpw_chk_sva.sv
`timescale 1ns/100ps
module dpw_chk(
  input wire CORE_CLK_IN,
  input wire RST_IN,
  input wire SEL_N_IN,
  input wire DIR_IN,
  input wire STEP_IN,
  input wire [6:0] NV_RDATA_IN,
  input wire [6:0] POS_OUT,
  input wire [99:0] TAP_SEL_OUT,
  input wire NV_WR_OUT,
  input wire [6:0] NV_WDATA_OUT,
  input wire READY_OUT
);
  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (RST_IN);
  a_tap_one_hot: assert property (TAP_SEL_OUT == (100'h1 << POS_OUT)) else $error("tap select not one-hot");
  a_tap_range: assert property (POS_OUT <= 7'h63) else $error("position beyond top tap");
  a_desel_hold: assert property (SEL_N_IN && READY_OUT |=> $stable(POS_OUT)) else $error("moved while off");
  a_step_up: assert property (
    $rose(STEP_IN) && !SEL_N_IN && READY_OUT && DIR_IN && POS_OUT < 7'h63 |=> POS_OUT == $past(POS_OUT) + 7'h01
  ) else $error("up step missed");
  a_step_down: assert property (
    $rose(STEP_IN) && !SEL_N_IN && READY_OUT && !DIR_IN && POS_OUT > 7'h00 |=> POS_OUT == $past(POS_OUT) - 7'h01
  ) else $error("down step missed");
  a_sat_top: assert property (
    $rose(STEP_IN) && !SEL_N_IN && READY_OUT && DIR_IN && POS_OUT == 7'h63 |=> POS_OUT == 7'h63
  ) else $error("counter left the top tap");
  a_sat_bottom: assert property (
    $rose(STEP_IN) && !SEL_N_IN && READY_OUT && !DIR_IN && POS_OUT == 7'h00 |=> POS_OUT == 7'h00
  ) else $error("counter left the bottom tap");
  a_save_data: assert property (NV_WR_OUT |-> NV_WDATA_OUT == POS_OUT) else $error("saved word wrong");
  a_save_cause: assert property (
    NV_WR_OUT |-> $past(SEL_N_IN) && !$past(SEL_N_IN, 2)
  ) else $error("save without deselect");
  a_load_pos: assert property (
    $rose(READY_OUT) |-> POS_OUT == (($past(NV_RDATA_IN) > 7'h63) ? 7'h63 : $past(NV_RDATA_IN))
  ) else $error("stored position not loaded");
endmodule // dpw_chk
bind dpw_top dpw_chk i_dpw_chk(
  .CORE_CLK_IN(CORE_CLK_IN),
  .RST_IN(RST_IN),
  .SEL_N_IN(SEL_N_IN),
  .DIR_IN(DIR_IN),
  .STEP_IN(STEP_IN),
  .NV_RDATA_IN(NV_RDATA_IN),
  .POS_OUT(POS_OUT),
  .TAP_SEL_OUT(TAP_SEL_OUT),
  .NV_WR_OUT(NV_WR_OUT),
  .NV_WDATA_OUT(NV_WDATA_OUT),
  .READY_OUT(READY_OUT)
);

// >>> bench/dpw_nvm.sv
`timescale 1ns/100ps
// Store word survives reset, as the cells do
module dpw_nvm(input wire clk_in, input wire wr_in, input wire [6:0] wdata_in, output reg [6:0] rdata_out);
  initial rdata_out = 7'h2A;
  always @(posedge clk_in) if (wr_in) rdata_out <= wdata_in;
endmodule // dpw_nvm

// >>> bench/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  reg clk = 0, rst = 1, sel_n = 1, dir = 0, step = 0, moved = 0;
  wire [6:0] pos, nvr, nvw;
  wire [99:0] tap;
  wire wr, rdy;
  integer fail_count = 0, compares = 0, seed = 32'h6A0D9B43, i;
  reg [31:0] rnd;
  reg [6:0] want_pos;
  reg [6:0] exp_q[$], wr_q[$], model = 7'h2A, last = 7'h2A;
  always #4 clk = ~clk;
  dpw_top i_dpw_top(.CORE_CLK_IN(clk), .RST_IN(rst), .SEL_N_IN(sel_n), .DIR_IN(dir), .STEP_IN(step),
    .NV_RDATA_IN(nvr), .POS_OUT(pos), .TAP_SEL_OUT(tap), .NV_WR_OUT(wr), .NV_WDATA_OUT(nvw), .READY_OUT(rdy));
  dpw_nvm i_dpw_nvm(.clk_in(clk), .wr_in(wr), .wdata_in(nvw), .rdata_out(nvr));
  task cmp(input [6:0] got, input [6:0] want); begin
    compares = compares + 1;
    if (got !== want) begin
      fail_count = fail_count + 1;
      $display("Error %0t got %h want %h", $time, got, want);
    end
  end endtask
  task cmp_tap(input [99:0] got, input [6:0] at); begin
    compares = compares + 1;
    if (got !== (100'h1 << at)) begin
      fail_count = fail_count + 1;
      $display("Error %0t tap select %h wrong for tap %0d", $time, got, at);
    end
  end endtask
  // Outputs are read at the falling edge, half a cycle after the edge that launched them
  // Only changes are noted, so a lost step shows as a leftover note
  always @(negedge clk) begin
    if (rdy === 1'b1 && pos !== last) begin
      last = pos;
      want_pos = exp_q.size() ? exp_q.pop_front() : ~pos;
      cmp(pos, want_pos);
      cmp_tap(tap, want_pos);
    end
    if (wr !== 1'b0) cmp(nvw, wr_q.size() ? wr_q.pop_front() : ~nvw);
  end
  task sel(input v); begin
    if (v && !sel_n && moved) wr_q.push_back(model);
    if (v) moved = 0;
    sel_n = v;
    @(posedge clk) #1;
  end endtask
  task stp(input d); begin
    dir = d;
    step = 0;
    @(posedge clk) #1 step = 1;
    if (!sel_n && (d ? model < 7'h63 : model > 7'h00)) begin
      model = d ? model + 7'h1 : model - 7'h1;
      exp_q.push_back(model);
      moved = 1;
    end
    @(posedge clk) #1;
  end endtask
  task tally_and_finish; begin
    if (exp_q.size() + wr_q.size()) begin
      fail_count = fail_count + 1;
      $display("Error %0t %0d expected results never seen", $time, exp_q.size() + wr_q.size());
    end
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  end endtask
  initial begin
    repeat (12) @(posedge clk);
    #1 rst = 0;
    sel(0);
    for (i = 0; i < 190; i = i + 1) stp(i < 80);
    $display("walk done");
    for (i = 0; i < 80; i = i + 1) begin
      sel(($random(seed) & 3) == 0);
      rnd = $random(seed);
      stp(rnd[0]);
    end
    sel(1);
    // Let the save strobe reach the store before power goes away
    repeat (2) @(posedge clk);
    #1;
    $display("random done");
    last = model;
    rst = 1;
    @(posedge clk) #1 rst = 0;
    repeat (3) @(posedge clk);
    #1;
    cmp(pos, model);
    cmp({6'h00, rdy}, 7'h01);
    $display("restore done");
    tally_and_finish;
  end
endmodule // tb_top
